// File: core/uart_irq_pkg.sv
// shared constants for the interrupt, sleep and modem-control block
package uart_irq_pkg;
	// register map (word addresses on the plain port)
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_MODEM = 3'h1;
	localparam logic [2:0] ADDR_ENABLE = 3'h2;
	localparam logic [2:0] ADDR_MODE = 3'h3;
	localparam logic [2:0] ADDR_PRESCALER = 3'h4;
	localparam logic [2:0] ADDR_SOURCES = 3'h5;
	// interrupt status codes, bits 5:0
	localparam logic [5:0] CODE_NONE = 6'h01;
	localparam logic [5:0] CODE_L1 = 6'h06;
	localparam logic [5:0] CODE_L2A = 6'h04;
	localparam logic [5:0] CODE_L2B = 6'h0c;
	localparam logic [5:0] CODE_L3 = 6'h02;
	localparam logic [5:0] CODE_L4 = 6'h00;
	localparam logic [5:0] CODE_L5 = 6'h10;
	localparam logic [5:0] CODE_L6 = 6'h20;
	// reset values
	localparam logic [7:0] MODEM_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] PRESCALER_RESET = 8'h20;
	// modem control fields
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUT_A = 2;
	localparam int MC_OUT_B = 3;
	localparam int MC_LOOP = 4;
	localparam int MC_FLOW = 5;
	localparam int MC_IRDA = 6;
	localparam int MC_PRESCALE = 7;
	// interrupt enable fields
	localparam int IE_RX_DATA = 0;
	localparam int IE_TX_EMPTY = 1;
	localparam int IE_RX_STATUS = 2;
	localparam int IE_MODEM = 3;
	localparam int IE_SLEEP = 4;
	localparam int IE_SPECIAL = 5;
	localparam int IE_RTS = 6;
	localparam int IE_CTS = 7;
	// mode register fields
	localparam int MODE_ENHANCED = 0;
	localparam int MODE_NINE_BIT = 1;
	localparam int MODE_ADDR_IRQ = 2;
	localparam int MODE_FIFO = 3;
	localparam int MODE_DEEP_FIFO = 4;
	localparam int MODE_TRIG_EN = 5;
	localparam int MODE_SPECIAL = 6;
	// timeout length in character times
	localparam int TIMEOUT_CHARS = 4;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// File: core/uart_irq_sleep_modem.sv
// interrupt identification, sleep control and modem control of one channel
// Behaviour
// - report only highest pending code
// - levels five and six need enhanced mode
// - status bit five depends on mode
// - level one from line errors, enable bit two
// - nine-bit: errors by bit three, address separately
// - nine-bit data error only framing or break
// - level 2a while fill above trigger
// - timeout after four idle character times
// - level three set below trigger, cleared
// - zero trigger waits for line idle
// - level four from modem deltas, read clears
// - level five from flow or special characters
// - level six on CTS or RTS rise
// - sleep only when every condition holds
// - sleep keeps state, exits automatically
// - bits zero, one drive DTR, RTS active low
// - bits two, three drive user pins
// - interrupt pin tristate by bit three
// - loopback forces outputs high, routes internally
// - bit five XON-any or hardware flow
// - bit six selects IrDA, enhanced only
// - bit seven prescaler, enhanced writes only
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module uart_irq_sleep_modem #(
	parameter int FILL_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// line status events and flags from receiver
	input wire logic line_status_read,
	input wire logic err_overrun,
	input wire logic err_parity,
	input wire logic err_framing,
	input wire logic err_break,
	// receive side
	input wire logic [FILL_W-1:0] rx_fill,
	input wire logic [FILL_W-1:0] rx_trigger,
	input wire logic rx_holding_read,
	input wire logic rx_holding_write,
	input wire logic char_tick,
	input wire logic rx_idle,
	// transmit side
	input wire logic [FILL_W-1:0] tx_fill,
	input wire logic [FILL_W-1:0] tx_trigger,
	input wire logic tx_shift_empty,
	// flow control and special character events
	input wire logic xoff_received,
	input wire logic second_stop_character_match,
	input wire logic special_match,
	input wire logic modem_status_read,
	// pins from the far side, active low
	input wire logic serial_in,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic dcd_n,
	input wire logic interrupt_mode_select_n,
	// pins to the far side
	output logic serial_out,
	input wire logic tx_serial,
	output logic dtr_n,
	output logic rts_n,
	output logic user_n_a,
	output logic user_n_b,
	output logic irq_out,
	output logic irq_oe,
	// to the rest of the channel
	output logic line_data_error,
	output logic loop_serial,
	output logic xon_any,
	output logic hw_flow,
	output logic irda_select,
	output logic prescaler_select,
	output logic [7:0] prescaler,
	output logic clock_off,
	output logic [7:0] modem_status
);
	// =====================================
	// state
	typedef struct packed {
		logic [7:0] modem_control;
		logic [7:0] interrupt_enable;
		logic [7:0] mode;
		logic [7:0] prescaler;
		logic [7:0] rdata;
		logic [3:0] pin_s1;
		logic [3:0] pin_s2;
		logic sin_s1;
		logic sin_s2;
		logic [3:0] lines_prev;
		logic [3:0] deltas;
		logic rts_prev;
		logic tx_low_prev;
		logic l3;
		logic l5;
		logic l6;
		logic asleep;
	} state_t;
	state_t state;
	state_t next_state;

	// =====================================
	// helpers
	function automatic logic [5:0] pick_code(input logic [6:0] p);
		// p order: l1, l2a, l2b, l3, l4, l5, l6
		if (p[0]) begin
			pick_code = uart_irq_pkg::CODE_L1;
		end else if (p[1]) begin
			pick_code = uart_irq_pkg::CODE_L2A;
		end else if (p[2]) begin
			pick_code = uart_irq_pkg::CODE_L2B;
		end else if (p[3]) begin
			pick_code = uart_irq_pkg::CODE_L3;
		end else if (p[4]) begin
			pick_code = uart_irq_pkg::CODE_L4;
		end else if (p[5]) begin
			pick_code = uart_irq_pkg::CODE_L5;
		end else if (p[6]) begin
			pick_code = uart_irq_pkg::CODE_L6;
		end else begin
			pick_code = uart_irq_pkg::CODE_NONE;
		end
	endfunction

	logic enh;
	logic nine;
	logic loop;
	logic [3:0] lines;
	logic l1;
	logic l2a;
	logic l2b;
	logic l4;
	logic [6:0] pend;
	logic [5:0] code;
	logic [7:0] status_byte;
	logic status_read;
	logic tx_low;
	logic sleep_req;
	logic sleep_ok;
	logic timeout;

	assign enh = state.mode[uart_irq_pkg::MODE_ENHANCED];
	assign nine = state.mode[uart_irq_pkg::MODE_NINE_BIT];
	assign loop = state.modem_control[uart_irq_pkg::MC_LOOP];
	assign status_read = rd && addr == uart_irq_pkg::ADDR_STATUS;

	// modem lines as asserted levels, dcd in bit 3 down to cts in bit 0
	always_comb begin
		if (loop) begin
			lines = {state.modem_control[uart_irq_pkg::MC_OUT_B], state.modem_control[uart_irq_pkg::MC_OUT_A],
				state.modem_control[uart_irq_pkg::MC_DTR], state.modem_control[uart_irq_pkg::MC_RTS]};
		end else begin
			lines = ~state.pin_s2;
		end
	end

	// =====================================
	// interrupt sources
	always_comb begin
		if (nine) begin
			l1 = ((err_overrun || err_framing || err_break) && state.interrupt_enable[uart_irq_pkg::IE_MODEM])
				|| (err_parity && state.mode[uart_irq_pkg::MODE_ADDR_IRQ]);
			line_data_error = err_framing || err_break;
		end else begin
			l1 = (err_overrun || err_parity || err_framing || err_break)
				&& state.interrupt_enable[uart_irq_pkg::IE_RX_STATUS];
			line_data_error = err_parity || err_framing || err_break;
		end
	end

	assign l2a = state.interrupt_enable[uart_irq_pkg::IE_RX_DATA] && rx_fill > rx_trigger;
	assign l2b = state.interrupt_enable[uart_irq_pkg::IE_RX_DATA] && timeout;
	assign l4 = state.interrupt_enable[uart_irq_pkg::IE_MODEM] && state.deltas != 4'h0;
	// level 5 and 6 flags are only ever set in enhanced mode
	assign pend = {state.l6 && enh, state.l5 && enh, l4,
		state.l3 && state.interrupt_enable[uart_irq_pkg::IE_TX_EMPTY], l2b, l2a, l1};
	assign code = pick_code(pend);

	always_comb begin
		status_byte = {2'b00, code};
		if (!enh) begin
			status_byte[5] = state.mode[uart_irq_pkg::MODE_DEEP_FIFO];
		end
	end

	// zero trigger with enhanced levels waits until the line is quiet
	always_comb begin
		if (state.mode[uart_irq_pkg::MODE_TRIG_EN] && tx_trigger == '0) begin
			tx_low = tx_fill == '0 && tx_shift_empty && serial_out;
		end else begin
			tx_low = tx_fill < tx_trigger;
		end
	end

	uart_rx_timeout #(
		.CHARS(uart_irq_pkg::TIMEOUT_CHARS)
	) timeout_counter (
		.clk(clk),
		.rst_n(rst_n),
		.enable(state.mode[uart_irq_pkg::MODE_FIFO] && rx_fill != '0),
		.char_tick(char_tick),
		.restart(rx_holding_read || rx_holding_write),
		.clear(rx_holding_read),
		.expired(timeout)
	);

	// =====================================
	// sleep
	assign sleep_req = enh ? state.interrupt_enable[uart_irq_pkg::IE_SLEEP]
		: state.interrupt_enable[uart_irq_pkg::IE_SPECIAL];
	// a pending interrupt keeps the clock running so software sees it
	assign sleep_ok = sleep_req && tx_fill == '0 && tx_shift_empty && state.sin_s2 && rx_idle && rx_fill == '0
		&& !loop && state.deltas == 4'h0 && code == uart_irq_pkg::CODE_NONE
		&& !state.modem_control[uart_irq_pkg::MC_IRDA];

	// =====================================
	// next state
	always_comb begin
		next_state = state;
		next_state.pin_s1 = {dcd_n, ri_n, dsr_n, cts_n};
		next_state.pin_s2 = state.pin_s1;
		next_state.sin_s1 = serial_in;
		next_state.sin_s2 = state.sin_s1;
		next_state.lines_prev = lines;
		next_state.rts_prev = rts_n;
		next_state.tx_low_prev = tx_low;
		next_state.asleep = sleep_ok;
		next_state.rdata = 8'h00;

		if (rd) begin
			case (addr)
				uart_irq_pkg::ADDR_STATUS: next_state.rdata = status_byte;
				uart_irq_pkg::ADDR_MODEM: next_state.rdata = state.modem_control;
				uart_irq_pkg::ADDR_ENABLE: begin
					next_state.rdata = state.interrupt_enable;
					// the request bit reads back whether sleep was entered
					if (enh) begin
						next_state.rdata[uart_irq_pkg::IE_SLEEP] = state.asleep;
					end else begin
						next_state.rdata[uart_irq_pkg::IE_SPECIAL] = state.asleep;
					end
				end
				uart_irq_pkg::ADDR_MODE: next_state.rdata = state.mode;
				uart_irq_pkg::ADDR_PRESCALER: next_state.rdata = state.prescaler;
				uart_irq_pkg::ADDR_SOURCES: next_state.rdata = {1'b0, pend};
				default: next_state.rdata = uart_irq_pkg::ZERO_BYTE;
			endcase
		end

		if (wr) begin
			case (addr)
				uart_irq_pkg::ADDR_MODEM: begin
					next_state.modem_control[6:0] = wdata[6:0];
					if (enh) begin
						next_state.modem_control[uart_irq_pkg::MC_PRESCALE] = wdata[7];
					end
				end
				uart_irq_pkg::ADDR_ENABLE: next_state.interrupt_enable = wdata;
				uart_irq_pkg::ADDR_MODE: next_state.mode = wdata;
				uart_irq_pkg::ADDR_PRESCALER: next_state.prescaler = wdata;
				default: next_state.mode = state.mode;
			endcase
		end

		// clears first, so a same-cycle event sets again below
		if (modem_status_read) begin
			next_state.deltas = 4'h0;
		end
		if (status_read && code == uart_irq_pkg::CODE_L3) begin
			next_state.l3 = 1'b0;
		end
		if (!tx_low) begin
			next_state.l3 = 1'b0;
		end
		if (status_read && code == uart_irq_pkg::CODE_L5) begin
			next_state.l5 = 1'b0;
		end
		if (status_read && code == uart_irq_pkg::CODE_L6) begin
			next_state.l6 = 1'b0;
		end

		// delta flags: cts, dsr, dcd on any change, ri on trailing edge
		next_state.deltas = next_state.deltas
			| ({lines[3], 1'b0, lines[1:0]} ^ {state.lines_prev[3], 1'b0, state.lines_prev[1:0]})
			| {1'b0, state.lines_prev[2] && !lines[2], 2'b00};
		// level 3 sets on the drop below trigger only, so a status read clear is not undone next cycle
		if (tx_low && !state.tx_low_prev) begin
			next_state.l3 = 1'b1;
		end
		if (enh && state.interrupt_enable[uart_irq_pkg::IE_SPECIAL]
			&& (xoff_received || (state.mode[uart_irq_pkg::MODE_SPECIAL] && second_stop_character_match)
			|| (nine && special_match))) begin
			next_state.l5 = 1'b1;
		end
		// cts rise read from synchronised levels; the first stage may still be settling
		if (enh && ((state.interrupt_enable[uart_irq_pkg::IE_CTS] && state.lines_prev[0] && !lines[0])
			|| (state.interrupt_enable[uart_irq_pkg::IE_RTS] && rts_n && !state.rts_prev))) begin
			next_state.l6 = 1'b1;
		end
	end

	// pins reset to their idle high level so no false edge follows reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '{modem_control: uart_irq_pkg::MODEM_RESET, interrupt_enable: uart_irq_pkg::ENABLE_RESET,
				mode: uart_irq_pkg::MODE_RESET, prescaler: uart_irq_pkg::PRESCALER_RESET, rdata: 8'h00,
				pin_s1: 4'hf, pin_s2: 4'hf, sin_s1: 1'b1, sin_s2: 1'b1, lines_prev: 4'h0, deltas: 4'h0,
				rts_prev: 1'b1, tx_low_prev: 1'b0, l3: 1'b0, l5: 1'b0, l6: 1'b0, asleep: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// =====================================
	// outputs
	assign rdata = state.rdata;
	assign dtr_n = loop || !state.modem_control[uart_irq_pkg::MC_DTR];
	assign rts_n = loop || !state.modem_control[uart_irq_pkg::MC_RTS];
	assign user_n_a = loop || state.modem_control[uart_irq_pkg::MC_OUT_A];
	assign user_n_b = loop || state.modem_control[uart_irq_pkg::MC_OUT_B];
	assign serial_out = loop || tx_serial;
	assign loop_serial = loop ? tx_serial : state.sin_s2;
	assign irq_out = code != uart_irq_pkg::CODE_NONE;
	assign irq_oe = interrupt_mode_select_n || state.modem_control[uart_irq_pkg::MC_OUT_B];
	assign xon_any = enh && state.modem_control[uart_irq_pkg::MC_FLOW];
	assign hw_flow = !enh && state.modem_control[uart_irq_pkg::MC_FLOW];
	assign irda_select = enh && state.modem_control[uart_irq_pkg::MC_IRDA];
	assign prescaler_select = state.modem_control[uart_irq_pkg::MC_PRESCALE];
	assign prescaler = state.prescaler;
	assign clock_off = state.asleep;
	assign modem_status = {lines, state.deltas};
endmodule

// File: core/uart_rx_timeout.sv
// receive time-out counter in character periods
`timescale 1ns/1ps
module uart_rx_timeout #(
	parameter int CHARS = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// conditions
	input wire logic enable,
	input wire logic char_tick,
	input wire logic restart,
	input wire logic clear,
	// result
	output logic expired
);
	// =====================================
	// state
	typedef struct packed {
		logic [3:0] count;
		logic expired;
	} state_t;
	state_t state;
	state_t next_state;

	always_comb begin
		next_state = state;
		if (!enable || restart) begin
			next_state.count = 4'h0;
		end else if (char_tick && state.count < 4'(CHARS)) begin
			next_state.count = state.count + 4'h1;
		end
		// the event wins over a clear in the same cycle
		if (clear || !enable) begin
			next_state.expired = 1'b0;
		end
		if (enable && !restart && char_tick && state.count == 4'(CHARS - 1)) begin
			next_state.expired = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign expired = state.expired;
endmodule

// File: tb/modem_far_end.sv
// far-end terminal model on the handshake lines
`timescale 1ns/1ps
module modem_far_end (
	// clock
	input wire logic clk,
	// pins from the block
	input wire logic dtr_n,
	input wire logic rts_n,
	// scenario controls
	input wire logic slow,
	input wire logic carrier,
	input wire logic ring,
	// pins to the block
	output logic cts_n,
	output logic dsr_n,
	output logic ri_n,
	output logic dcd_n,
	output logic serial_in
);
	// ==========================================
	// terminal answers ready with ready, slow mode lags four cycles
	logic [3:0] dtr_d = 4'hf;
	logic [3:0] rts_d = 4'hf;
	always_ff @(posedge clk) begin
		dtr_d <= {dtr_d[2:0], dtr_n};
		rts_d <= {rts_d[2:0], rts_n};
	end
	assign dsr_n = slow ? dtr_d[3] : dtr_d[0];
	assign cts_n = slow ? rts_d[3] : rts_d[0];
	assign ri_n = !ring;
	assign dcd_n = !carrier;
	// line rests at mark, no frames sent
	assign serial_in = 1'b1;
endmodule

// File: tb/uart_irq_sleep_modem_chk.sv
// concurrent checks on the interrupt, sleep and modem-control block
`timescale 1ns/1ps
module uart_irq_sleep_modem_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	// inputs watched
	input wire logic rx_idle,
	input wire logic tx_serial,
	input wire logic interrupt_mode_select_n,
	// outputs watched
	input wire logic serial_out,
	input wire logic dtr_n,
	input wire logic rts_n,
	input wire logic user_n_a,
	input wire logic user_n_b,
	input wire logic irq_out,
	input wire logic irq_oe,
	input wire logic irda_select,
	input wire logic prescaler_select,
	input wire logic [7:0] prescaler,
	input wire logic clock_off
);
	// ==========================================
	// sequences
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_mc_wr;
		wr && addr == uart_irq_pkg::ADDR_MODEM;
	endsequence
	sequence s_mc_norm;
		s_mc_wr ##0 !wdata[uart_irq_pkg::MC_LOOP];
	endsequence
	// ==========================================
	// properties
	a_hs_pins: assert property (s_mc_norm |=> dtr_n == !$past(wdata[0]) && rts_n == !$past(wdata[1]))
		else $error("handshake pin level wrong");
	a_user_pins: assert property (s_mc_norm |=> user_n_a == $past(wdata[2]) && user_n_b == $past(wdata[3]))
		else $error("user pin level wrong");
	a_loop_high: assert property (s_mc_wr ##0 wdata[4] |=> serial_out && dtr_n && rts_n && user_n_a && user_n_b)
		else $error("loopback outputs not high");
	a_serial_out_pass: assert property (!dtr_n |-> serial_out == tx_serial)
		else $error("serial out not following transmitter");
	a_irq_gate: assert property (s_mc_wr ##0 !interrupt_mode_select_n |=> irq_oe == $past(wdata[3]))
		else $error("interrupt drive enable wrong");
	a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not zero outside read");
	a_status_pend: assert property (rd && addr == uart_irq_pkg::ADDR_STATUS |=> rdata[0] == !$past(irq_out))
		else $error("status pending bit disagrees with interrupt");
	a_reset_vals: assert property (!$past(rst_n) |-> prescaler == 8'h20 && !prescaler_select && dtr_n && rts_n)
		else $error("reset values wrong");
	a_sleep_exit: assert property (!rx_idle [*2] |-> !clock_off)
		else $error("clock off while receiver busy");
	a_irda_awake: assert property (irda_select [*2] |-> !clock_off)
		else $error("clock off in infrared mode");
endmodule

// File: tb/uart_irq_sleep_modem_tb.sv
// self-checking bench for the interrupt, sleep and modem-control block
`timescale 1ns/1ps
module uart_irq_sleep_modem_tb;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata, d, prescaler, modem_status;
	logic [7:0] rx_fill = 8'h00, rx_trigger = 8'h04, tx_fill = 8'h00, tx_trigger = 8'h00;
	logic e_ovr = 1'b0, e_par = 1'b0, e_frm = 1'b0, e_brk = 1'b0, hrd = 1'b0, hwr = 1'b0, tick = 1'b0;
	logic rx_idle = 1'b1, shift_empty = 1'b1, xoff = 1'b0, ms_read = 1'b0, sel_n = 1'b0, tx_serial = 1'b1;
	logic slow = 1'b0, carrier = 1'b0, ring = 1'b0, ssm = 1'b0, spm = 1'b0;
	logic serial_in, cts_n, dsr_n, ri_n, dcd_n, serial_out, dtr_n, rts_n, user_n_a, user_n_b;
	logic irq_out, irq_oe, line_data_error, loop_serial, xon_any, hw_flow, irda_select, prescaler_select, clock_off;
	logic [15:0] exp_q[$];
	logic [15:0] ent;
	int failures = 0, num_checks = 0;
	initial forever #50 clk = ~clk;
	uart_irq_sleep_modem uart_irq_sleep_modem_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
		.line_status_read(1'b0), .err_overrun(e_ovr), .err_parity(e_par), .err_framing(e_frm), .err_break(e_brk),
		.rx_fill, .rx_trigger, .rx_holding_read(hrd), .rx_holding_write(hwr), .char_tick(tick), .rx_idle,
		.tx_fill, .tx_trigger, .tx_shift_empty(shift_empty), .xoff_received(xoff),
		.second_stop_character_match(ssm), .special_match(spm), .modem_status_read(ms_read),
		.serial_in, .cts_n, .dsr_n, .ri_n, .dcd_n, .interrupt_mode_select_n(sel_n), .serial_out, .tx_serial,
		.dtr_n, .rts_n, .user_n_a, .user_n_b, .irq_out, .irq_oe, .line_data_error, .loop_serial,
		.xon_any, .hw_flow, .irda_select, .prescaler_select, .prescaler, .clock_off, .modem_status);
	modem_far_end modem_far_end_inst (.clk, .dtr_n, .rts_n, .slow, .carrier, .ring,
		.cts_n, .dsr_n, .ri_n, .dcd_n, .serial_in);
	// ==========================================
	// tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk) wr <= 1'b0;
	endtask
	// expectation is queued with its mask before the strobe goes out
	task automatic rreg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back({m, e});
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk) rd <= 1'b0;
	endtask
	task automatic close_out;
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================
	// read data monitor, one cycle behind the strobe
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d) begin
			ent = exp_q.pop_front();
			chk("rdata", ent[7:0], rdata & ent[15:8]);
		end
	end
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		close_out();
	end
	// ==========================================
	// scenarios
	initial begin
		void'($urandom(33406));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rreg(uart_irq_pkg::ADDR_MODEM, 8'h00, 8'hff);
		rreg(uart_irq_pkg::ADDR_PRESCALER, 8'h20, 8'hff);
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h01, 8'h3f);
		rreg(3'h7, 8'h00, 8'hff);
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom()) & 8'h8f;
			tx_serial <= d[1];
			sel_n <= i[0];
			wreg(uart_irq_pkg::ADDR_MODEM, d);
			@(negedge clk);
			chk("pins", {4'h0, ~d[0], ~d[1], d[3:2]}, {4'h0, dtr_n, rts_n, user_n_b, user_n_a});
			rreg(uart_irq_pkg::ADDR_MODEM, d & 8'h0f, 8'hff);
		end
		tx_serial <= 1'b0;
		wreg(uart_irq_pkg::ADDR_MODEM, 8'h1f);
		repeat (4) @(negedge clk);
		chk("loop pins", 8'h1f, {3'h0, serial_out, dtr_n, rts_n, user_n_a, user_n_b});
		chk("loop status", 8'h0f, {4'h0, modem_status[7:4]});
		chk("loop serial", 8'h00, {7'h0, loop_serial});
		wreg(uart_irq_pkg::ADDR_MODE, 8'h01);
		wreg(uart_irq_pkg::ADDR_MODEM, 8'he0);
		rreg(uart_irq_pkg::ADDR_MODEM, 8'he0, 8'hff);
		chk("enh ctl", 8'h0b, {4'h0, xon_any, hw_flow, irda_select, prescaler_select});
		wreg(uart_irq_pkg::ADDR_MODEM, 8'h00);
		wreg(uart_irq_pkg::ADDR_MODE, 8'h00);
		wreg(uart_irq_pkg::ADDR_MODEM, 8'h60);
		@(negedge clk);
		chk("std ctl", 8'h04, {4'h0, xon_any, hw_flow, irda_select, prescaler_select});
		wreg(uart_irq_pkg::ADDR_MODE, 8'h02);
		e_par <= 1'b1;
		repeat (2) @(negedge clk);
		chk("data err", 8'h00, {7'h0, line_data_error});
		e_frm <= 1'b1;
		repeat (2) @(negedge clk);
		chk("data err", 8'h01, {7'h0, line_data_error});
		e_frm <= 1'b0;
		wreg(uart_irq_pkg::ADDR_MODE, 8'h00);
		wreg(uart_irq_pkg::ADDR_MODEM, 8'h00);
		repeat (6) @(posedge clk);
		@(posedge clk) ms_read <= 1'b1;
		@(posedge clk) ms_read <= 1'b0;
		wreg(uart_irq_pkg::ADDR_ENABLE, 8'h0f);
		rx_fill <= 8'h09;
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h06, 8'h3f);
		e_par <= 1'b0;
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h04, 8'h3f);
		rx_fill <= 8'h04;
		tx_trigger <= 8'h02;
		tx_fill <= 8'h01;
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h02, 8'h3f);
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h01, 8'h3f);
		tx_fill <= 8'h03;
		carrier <= 1'b1;
		repeat (4) @(posedge clk);
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h00, 8'h3f);
		@(posedge clk) ms_read <= 1'b1;
		@(posedge clk) ms_read <= 1'b0;
		rx_fill <= 8'h01;
		wreg(uart_irq_pkg::ADDR_MODE, 8'h08);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk) tick <= 1'b1;
			@(posedge clk) tick <= 1'b0;
			if (i == 2)
				rreg(uart_irq_pkg::ADDR_STATUS, 8'h01, 8'h3f);
		end
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h0c, 8'h3f);
		@(posedge clk) hrd <= 1'b1;
		@(posedge clk) hrd <= 1'b0;
		rx_fill <= 8'h00;
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h01, 8'h3f);
		wreg(uart_irq_pkg::ADDR_MODE, 8'h18);
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h21, 8'h3f);
		wreg(uart_irq_pkg::ADDR_MODE, 8'h00);
		wreg(uart_irq_pkg::ADDR_ENABLE, 8'h60);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) xoff <= 1'b1;
			@(posedge clk) xoff <= 1'b0;
			rreg(uart_irq_pkg::ADDR_STATUS, i ? 8'h10 : 8'h01, 8'h3f);
			wreg(uart_irq_pkg::ADDR_MODE, 8'h01);
		end
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h01, 8'h3f);
		for (int i = 0; i < 2; i++) begin
			wreg(uart_irq_pkg::ADDR_MODE, i ? 8'h03 : 8'h41);
			@(posedge clk) {spm, ssm} <= i ? 2'b10 : 2'b01;
			@(posedge clk) {spm, ssm} <= 2'b00;
			rreg(uart_irq_pkg::ADDR_STATUS, 8'h10, 8'h3f);
		end
		wreg(uart_irq_pkg::ADDR_MODE, 8'h01);
		slow <= 1'b1;
		wreg(uart_irq_pkg::ADDR_MODEM, 8'h02);
		wreg(uart_irq_pkg::ADDR_MODEM, 8'h00);
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h20, 8'h3f);
		rreg(uart_irq_pkg::ADDR_STATUS, 8'h01, 8'h3f);
		repeat (8) @(posedge clk);
		@(posedge clk) ms_read <= 1'b1;
		@(posedge clk) ms_read <= 1'b0;
		tx_fill <= 8'h00;
		wreg(uart_irq_pkg::ADDR_ENABLE, 8'h10);
		for (int i = 0; i < 20 && clock_off !== 1'b1; i++)
			@(negedge clk);
		chk("clock off", 8'h01, {7'h0, clock_off});
		rreg(uart_irq_pkg::ADDR_ENABLE, 8'h10, 8'h10);
		rreg(uart_irq_pkg::ADDR_PRESCALER, 8'h20, 8'hff);
		rx_idle <= 1'b0;
		repeat (3) @(negedge clk);
		chk("clock off", 8'h00, {7'h0, clock_off});
		rx_idle <= 1'b1;
		repeat (3) @(posedge clk);
		close_out();
	end
endmodule
bind uart_irq_sleep_modem uart_irq_sleep_modem_chk chk_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
	.rx_idle, .tx_serial, .interrupt_mode_select_n, .serial_out, .dtr_n, .rts_n, .user_n_a, .user_n_b,
	.irq_out, .irq_oe, .irda_select, .prescaler_select, .prescaler, .clock_off);
